/* core/programmable_protection_stage.sv */
// Contract
// - keep eight latest breaker-failure fault records
// - elapsed delay as percent, 100 is trip
// - selector picks one supervised measured quantity
// - over or under compare direction
// - pick-up limit in selected quantity's units
// - trip after fault persists for delay
// - percent dead band around the limit
// - under mode ignores values below floor
// - derived sequence, ratio, average quantities selectable
`timescale 1ns/1ps
`include "prog_stage_defs.svh"
module programmable_protection_stage #(
  parameter int NUM_Q = 27,
  parameter int MS_CYCLES = `MS_CYCLES_DEF,
  parameter int LOG_DEPTH = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire prog_stage_pkg::word_t haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire prog_stage_pkg::word_t hwdata,
  output prog_stage_pkg::word_t hrdata,
  output logic hreadyout,
  output logic hresp,
  // measurement subsystem, one word per quantity
  input wire logic [NUM_Q*32-1:0] meas_values,
  // breaker failure stage record request
  input wire logic bf_record,
  input wire logic [15:0] bf_elapsed_ms,
  input wire logic [15:0] bf_delay_ms,
  // real time clock
  input wire prog_stage_pkg::word_t rtc_date,
  input wire prog_stage_pkg::word_t rtc_time_ms,
  // stage outputs
  output logic stage_start,
  output logic stage_trip,
  output logic irq
);
  import prog_stage_pkg::*;

  if (NUM_Q < 27 || NUM_Q > 32 || MS_CYCLES < 1 || LOG_DEPTH != 8) begin : g_chk
    $error("programmable_protection_stage parameters out of range");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] pct_of(input logic [15:0] run, input logic [15:0] dly);
    logic [23:0] prod;
    logic [23:0] q;
    prod = 24'({8'h00, run} * 24'd100);
    q = (dly == 16'h0000) ? 24'd100 : prod / {8'h00, dly};
    pct_of = (q > 24'h00FFFF) ? 16'hFFFF : q[15:0];
  endfunction : pct_of

  function automatic logic [15:0] period_ms(input logic [1:0] code);
    unique case (code)
      period_fast: period_ms = `PERIOD_FAST_MS;
      period_mid: period_ms = `PERIOD_MID_MS;
      default: period_ms = `PERIOD_SLOW_MS;
    endcase
  endfunction : period_ms

  // ----------------------------------------------------------------
  // bus phase tracking
  // ----------------------------------------------------------------
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  word_t rdata_reg, rdata_next;
  word_t rd_val;
  logic take;

  assign take = hsel & hready & htrans[1];

  always_comb begin
    wr_pend_next = take & hwrite;
    wr_addr_next = take ? haddr[7:0] : wr_addr_reg;
    rdata_next = rdata_reg;
    if (take && !hwrite) begin
      rdata_next = rd_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [3:0] ctrl_reg, ctrl_next;
  logic [4:0] sel_reg, sel_next;
  word_t pickup_reg, pickup_next;
  logic [15:0] delay_reg, delay_next;
  logic [7:0] hyst_reg, hyst_next;
  word_t floor_reg, floor_next;
  logic [2:0] mask_reg, mask_next;
  logic [2:0] log_idx_reg, log_idx_next;
  logic [2:0] irq_reg, irq_next;
  logic [2:0] events;
  logic wr_hit;

  assign wr_hit = wr_pend_reg;

  always_comb begin
    ctrl_next = ctrl_reg;
    sel_next = sel_reg;
    pickup_next = pickup_reg;
    delay_next = delay_reg;
    hyst_next = hyst_reg;
    floor_next = floor_reg;
    mask_next = mask_reg;
    log_idx_next = log_idx_reg;
    irq_next = irq_reg | events;
    if (wr_hit) begin
      unique case (wr_addr_reg)
        `OFS_CTRL: ctrl_next = hwdata[3:0];
        `OFS_SELECT: sel_next = hwdata[4:0];
        `OFS_PICKUP: pickup_next = hwdata;
        `OFS_DELAY: delay_next = hwdata[15:0];
        `OFS_HYST: hyst_next = hwdata[7:0];
        `OFS_FLOOR: floor_next = hwdata;
        `OFS_IRQ_MASK: mask_next = hwdata[2:0];
        `OFS_LOG_INDEX: log_idx_next = hwdata[2:0];
        // set wins over the write-one clear
        `OFS_IRQ_STATUS: irq_next = (irq_reg & ~hwdata[2:0]) | events;
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= 4'(`CTRL_RST);
      sel_reg <= `SELECT_RST;
      pickup_reg <= `PICKUP_RST;
      delay_reg <= `DELAY_RST;
      hyst_reg <= `HYST_RST;
      floor_reg <= `FLOOR_RST;
      mask_reg <= `MASK_RST;
      log_idx_reg <= 3'h0;
      irq_reg <= 3'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      sel_reg <= sel_next;
      pickup_reg <= pickup_next;
      delay_reg <= delay_next;
      hyst_reg <= hyst_next;
      floor_reg <= floor_next;
      mask_reg <= mask_next;
      log_idx_reg <= log_idx_next;
      irq_reg <= irq_next;
    end
  end

  assign irq = |(irq_reg & mask_reg);

  // ----------------------------------------------------------------
  // evaluation timing and stage state
  // ----------------------------------------------------------------
  logic [31:0] ms_cnt_reg, ms_cnt_next;
  logic [15:0] per_cnt_reg, per_cnt_next;
  stage_state_t state_reg, state_next;
  logic [15:0] elapsed_reg, elapsed_next;
  word_t value_reg, value_next;
  logic [15:0] pct_reg, pct_next;
  logic [15:0] per_ms;
  logic ms_tick, eval_tick, under, enable;
  word_t sel_val;
  logic signed [33:0] v, lim, band, flr, lim_abs;
  logic [39:0] band_prod;
  logic start_cond, hold_cond, fault;
  logic [16:0] run_sum;

  assign enable = ctrl_reg[`CTRL_ENABLE_BIT];
  assign under = ctrl_reg[`CTRL_UNDER_BIT];
  assign per_ms = period_ms(ctrl_reg[`CTRL_PERIOD_LSB +: 2]);
  assign ms_tick = (ms_cnt_reg == 32'(MS_CYCLES - 1));
  assign eval_tick = ms_tick && (per_cnt_reg >= per_ms - 16'd1);

  // derived quantities are ordinary inputs of the selector
  assign sel_val = ({1'b0, sel_reg} < 6'(NUM_Q)) ?
    meas_values[sel_reg*32 +: 32] : 32'h0000_0000;

  always_comb begin
    v = 34'(signed'(sel_val));
    lim = 34'(signed'(pickup_reg));
    flr = 34'(signed'(floor_reg));
    lim_abs = (lim < 0) ? -lim : lim;
    band_prod = 40'(lim_abs) * 40'(hyst_reg);
    band = 34'(band_prod / 40'd100);
    if (under) begin
      start_cond = (v < lim) && (v >= flr);
      hold_cond = (v <= lim + band) && (v >= flr);
    end else begin
      start_cond = v > lim;
      hold_cond = v >= lim - band;
    end
    fault = (state_reg == st_idle) ? start_cond : hold_cond;
  end

  assign run_sum = {1'b0, elapsed_reg} + {1'b0, per_ms};

  always_comb begin
    ms_cnt_next = ms_tick ? 32'h0000_0000 : ms_cnt_reg + 32'd1;
    per_cnt_next = per_cnt_reg;
    if (ms_tick) begin
      per_cnt_next = eval_tick ? 16'h0000 : per_cnt_reg + 16'd1;
    end
    state_next = state_reg;
    elapsed_next = elapsed_reg;
    value_next = value_reg;
    events[`IRQ_START_BIT] = 1'b0;
    events[`IRQ_TRIP_BIT] = 1'b0;
    events[`IRQ_LOG_BIT] = bf_record;
    if (!enable) begin
      state_next = st_idle;
      elapsed_next = 16'h0000;
    end else if (eval_tick) begin
      value_next = sel_val;
      unique case (state_reg)
        st_idle: begin
          if (fault) begin
            state_next = st_started;
            elapsed_next = 16'h0000;
            events[`IRQ_START_BIT] = 1'b1;
          end
        end
        st_started: begin
          if (!fault) begin
            state_next = st_idle;
            elapsed_next = 16'h0000;
          end else begin
            elapsed_next = run_sum[16] ? 16'hFFFF : run_sum[15:0];
            if (run_sum >= {1'b0, delay_reg}) begin
              state_next = st_tripped;
              events[`IRQ_TRIP_BIT] = 1'b1;
            end
          end
        end
        st_tripped: begin
          if (!fault) begin
            state_next = st_idle;
            elapsed_next = 16'h0000;
          end
        end
      endcase
    end
    pct_next = (state_next == st_tripped) ? `FULL_PCT : pct_of(elapsed_next, delay_reg);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_reg <= 32'h0000_0000;
      per_cnt_reg <= 16'h0000;
      state_reg <= st_idle;
      elapsed_reg <= 16'h0000;
      value_reg <= 32'h0000_0000;
      pct_reg <= 16'h0000;
    end else begin
      ms_cnt_reg <= ms_cnt_next;
      per_cnt_reg <= per_cnt_next;
      state_reg <= state_next;
      elapsed_reg <= elapsed_next;
      value_reg <= value_next;
      pct_reg <= pct_next;
    end
  end

  assign stage_start = (state_reg != st_idle);
  assign stage_trip = (state_reg == st_tripped);

  // ----------------------------------------------------------------
  // breaker failure fault records
  // ----------------------------------------------------------------
  fault_log_if #(.IDX_W(3)) log_bus ();

  assign log_bus.wr = bf_record;
  assign log_bus.wr_date = rtc_date;
  assign log_bus.wr_time = rtc_time_ms;
  assign log_bus.wr_pct = pct_of(bf_elapsed_ms, bf_delay_ms);
  assign log_bus.rd_idx = log_idx_reg;

  fault_log #(.DEPTH(LOG_DEPTH), .IDX_W(3)) u_log (
    .hclk(hclk),
    .hresetn(hresetn),
    .bus(log_bus.store)
  );

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (haddr[7:0])
      `OFS_CTRL: rd_val = {28'h0, ctrl_reg};
      `OFS_SELECT: rd_val = {27'h0, sel_reg};
      `OFS_PICKUP: rd_val = pickup_reg;
      `OFS_DELAY: rd_val = {16'h0, delay_reg};
      `OFS_HYST: rd_val = {24'h0, hyst_reg};
      `OFS_FLOOR: rd_val = floor_reg;
      `OFS_STATUS: rd_val = {pct_reg, 14'h0, stage_trip, stage_start};
      `OFS_IRQ_STATUS: rd_val = {29'h0, irq_reg};
      `OFS_IRQ_MASK: rd_val = {29'h0, mask_reg};
      `OFS_VALUE: rd_val = value_reg;
      `OFS_LOG_INDEX: rd_val = {29'h0, log_idx_reg};
      `OFS_LOG_DATE: rd_val = log_bus.rd_date;
      `OFS_LOG_TIME: rd_val = log_bus.rd_time;
      `OFS_LOG_PCT: rd_val = {12'h0, log_bus.count, log_bus.rd_pct};
      default: rd_val = 32'h0000_0000;
    endcase
  end

endmodule : programmable_protection_stage

/* core/prog_stage_defs.svh */
`ifndef PROG_STAGE_DEFS_SVH
`define PROG_STAGE_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_SELECT 8'h04
`define OFS_PICKUP 8'h08
`define OFS_DELAY 8'h0C
`define OFS_HYST 8'h10
`define OFS_FLOOR 8'h14
`define OFS_STATUS 8'h18
`define OFS_IRQ_STATUS 8'h1C
`define OFS_IRQ_MASK 8'h20
`define OFS_VALUE 8'h24
`define OFS_LOG_INDEX 8'h28
`define OFS_LOG_DATE 8'h2C
`define OFS_LOG_TIME 8'h30
`define OFS_LOG_PCT 8'h34

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_ENABLE_BIT 0
`define CTRL_UNDER_BIT 1
`define CTRL_PERIOD_LSB 2
`define STATUS_START_BIT 0
`define STATUS_TRIP_BIT 1
`define STATUS_PCT_LSB 16
`define IRQ_START_BIT 0
`define IRQ_TRIP_BIT 1
`define IRQ_LOG_BIT 2
`define LOG_COUNT_LSB 16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RST 32'h0000_0000
`define SELECT_RST 5'h00
`define PICKUP_RST 32'h0000_0000
`define DELAY_RST 16'h0064
`define HYST_RST 8'h03
`define FLOOR_RST 32'h0000_0000
`define MASK_RST 3'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define MS_NS 1000000
`define MS_CYCLES_DEF (`MS_NS / `CLK_PERIOD_NS)
`define PERIOD_FAST_MS 16'd10
`define PERIOD_MID_MS 16'd20
`define PERIOD_SLOW_MS 16'd100
`define FULL_PCT 16'd100

`endif

/* core/prog_stage_pkg.sv */
package prog_stage_pkg;

  typedef logic [31:0] word_t;

  typedef enum logic [4:0] {
    q_il1, q_il2, q_il3, q_io1, q_io2,
    q_u12, q_u23, q_u31, q_ul1, q_ul2, q_ul3, q_uo,
    q_freq, q_p, q_q, q_s, q_cos_phi,
    q_calc_residual_current, q_i1, q_i2, q_i2_i1, q_i2_in,
    q_u1, q_u2, q_u2_u1, q_il_avg, q_uphase_avg
  } quantity_t;

  typedef enum logic [1:0] {
    period_fast, period_mid, period_slow
  } period_t;

  typedef enum {
    st_idle, st_started, st_tripped
  } stage_state_t;

endpackage : prog_stage_pkg

/* core/fault_log_if.sv */
`timescale 1ns/1ps
interface fault_log_if #(parameter int IDX_W = 3);
  logic wr;
  logic [31:0] wr_date;
  logic [31:0] wr_time;
  logic [15:0] wr_pct;
  logic [IDX_W-1:0] rd_idx;
  logic [31:0] rd_date;
  logic [31:0] rd_time;
  logic [15:0] rd_pct;
  logic [IDX_W:0] count;

  modport writer (
    output wr, wr_date, wr_time, wr_pct, rd_idx,
    input rd_date, rd_time, rd_pct, count
  );
  modport store (
    input wr, wr_date, wr_time, wr_pct, rd_idx,
    output rd_date, rd_time, rd_pct, count
  );
endinterface : fault_log_if

/* core/fault_log.sv */
`timescale 1ns/1ps
module fault_log #(
  parameter int DEPTH = 8,
  parameter int IDX_W = 3
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // record port
  fault_log_if.store bus
);
  import prog_stage_pkg::*;

  if (DEPTH != (1 << IDX_W)) begin : g_chk
    $error("fault_log depth must equal two to the index width");
  end

  logic [31:0] date_reg [DEPTH];
  logic [31:0] time_reg [DEPTH];
  logic [15:0] pct_reg [DEPTH];
  logic [31:0] date_next [DEPTH];
  logic [31:0] time_next [DEPTH];
  logic [15:0] pct_next [DEPTH];
  logic [IDX_W-1:0] ptr_reg, ptr_next;
  logic [IDX_W:0] count_reg, count_next;
  logic [IDX_W-1:0] rd_addr;

  // ----------------------------------------------------------------
  // circular store, oldest record overwritten
  // ----------------------------------------------------------------
  always_comb begin
    date_next = date_reg;
    time_next = time_reg;
    pct_next = pct_reg;
    ptr_next = ptr_reg;
    count_next = count_reg;
    if (bus.wr) begin
      date_next[ptr_reg] = bus.wr_date;
      time_next[ptr_reg] = bus.wr_time;
      pct_next[ptr_reg] = bus.wr_pct;
      ptr_next = ptr_reg + 1'b1;
      if (count_reg != (IDX_W+1)'(DEPTH)) begin
        count_next = count_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        date_reg[i] <= 32'h0000_0000;
        time_reg[i] <= 32'h0000_0000;
        pct_reg[i] <= 16'h0000;
      end
      ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      date_reg <= date_next;
      time_reg <= time_next;
      pct_reg <= pct_next;
      ptr_reg <= ptr_next;
      count_reg <= count_next;
    end
  end

  // index 0 is the newest record
  assign rd_addr = ptr_reg - bus.rd_idx - 1'b1;
  assign bus.rd_date = date_reg[rd_addr];
  assign bus.rd_time = time_reg[rd_addr];
  assign bus.rd_pct = pct_reg[rd_addr];
  assign bus.count = count_reg;

endmodule : fault_log

/* bench/meas_model.sv */
`timescale 1ns/1ps
module meas_model #(
  parameter int NUM_Q = 27
) (
  // clock
  input wire logic hclk,
  // bench control
  input wire logic set_en,
  input wire logic [4:0] set_idx,
  input wire logic [31:0] set_val,
  // computed quantities
  output logic [NUM_Q*32-1:0] meas_values
);
  initial meas_values = '0;
  // one quantity word changes at a time, others keep their level
  always @(posedge hclk) begin
    if (set_en) begin
      meas_values[set_idx*32 +: 32] <= set_val;
    end
  end
endmodule : meas_model

/* bench/prog_stage_properties.sv */
`timescale 1ns/1ps
module prog_stage_checker #(
  parameter int MS_CYCLES = 4
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire prog_stage_pkg::word_t haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire prog_stage_pkg::word_t hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // stage
  input wire logic stage_start,
  input wire logic stage_trip,
  input wire logic irq
);
  import prog_stage_pkg::*;
  logic rd_take;
  logic start_d_reg;
  logic start_d_next;
  int unsigned run_reg;
  int unsigned run_next;
  int unsigned cyc_reg;
  int unsigned cyc_next;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  // cycles since the stage last started
  always_comb begin
    start_d_next = stage_start;
    cyc_next = cyc_reg + 1;
    run_next = (stage_start && !start_d_reg) ? 1 : run_reg + 1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_d_reg <= 1'b0;
      run_reg <= 0;
      cyc_reg <= 0;
    end else begin
      start_d_reg <= start_d_next;
      run_reg <= run_next;
      cyc_reg <= cyc_next;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_okay_resp: assert property (hresp == 1'b0) else $error("response not okay");
  a_zero_wait: assert property (hreadyout == 1'b1) else $error("wait state seen");
  a_unmapped_zero: assert property (rd_take && haddr[7:0] > 8'h34 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!rd_take |=> $stable(hrdata)) else $error("hrdata moved");
  a_reset_quiet: assert property ($rose(hresetn) |-> !stage_start && !stage_trip && !irq)
    else $error("outputs active after reset");
  a_trip_in_start: assert property (stage_trip |-> stage_start)
    else $error("trip without start");
  a_trip_after_start: assert property ($rose(stage_trip) |-> $past(stage_start))
    else $error("trip not preceded by start");
  a_trip_on_tick: assert property ($rose(stage_trip) |-> run_reg != 0 && run_reg % MS_CYCLES == 0)
    else $error("trip off the tick grid");
  a_trip_drop_idle: assert property ($fell(stage_trip) |-> !stage_start)
    else $error("trip fell to started");
  a_start_on_tick: assert property ($rose(stage_start) |-> cyc_reg % MS_CYCLES == 0)
    else $error("start off the tick grid");
  cover property ($rose(stage_trip));
  cover property ($fell(stage_start));
  cover property ($rose(irq));
endmodule : prog_stage_checker

bind programmable_protection_stage prog_stage_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .stage_start(stage_start), .stage_trip(stage_trip), .irq(irq));

/* bench/programmable_protection_stage_tb.sv */
`timescale 1ns/1ps
module programmable_protection_stage_tb;
  import prog_stage_pkg::*;
  typedef struct {string n; word_t v;} note_t;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  word_t haddr = 32'h0, hwdata = 32'h0, hrdata, rtc_date = 32'h0, rtc_time_ms = 32'h0;
  logic [15:0] bf_elapsed_ms = 16'h0, bf_delay_ms = 16'h0;
  logic bf_record = 1'b0, stage_start, stage_trip, irq, set_en = 1'b0, rd_dp = 1'b0;
  logic [4:0] set_idx = 5'h0;
  word_t set_val = 32'h0, v;
  logic [27*32-1:0] meas_values;
  note_t exp_q[$];
  int fails = 0, num_checks = 0, cyc = 0, n, p, e;
  int seed = 32'h951ACC2B;
  int pt[4] = '{10, 20, 100, 100};
  int dl[4] = '{30, 400, 1000, 1250};
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;

  programmable_protection_stage #(.NUM_Q(27), .MS_CYCLES(4), .LOG_DEPTH(8)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .meas_values(meas_values), .bf_record(bf_record),
    .bf_elapsed_ms(bf_elapsed_ms), .bf_delay_ms(bf_delay_ms), .rtc_date(rtc_date),
    .rtc_time_ms(rtc_time_ms), .stage_start(stage_start), .stage_trip(stage_trip), .irq(irq));
  meas_model #(.NUM_Q(27)) u_meas (.hclk(hclk), .set_en(set_en), .set_idx(set_idx),
    .set_val(set_val), .meas_values(meas_values));

  // ----------------------------------------------------------------
  // bus tasks and scoreboard
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input word_t s, input word_t x);
    num_checks++;
    if (s !== x) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic bus(input logic [7:0] a, input logic w, input word_t d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_dp <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input word_t d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input word_t x);
    exp_q.push_back('{$sformatf("reg %h", a), x});
    bus(a, 1'b0, 32'h0);
  endtask : rd

  task automatic setv(input word_t d);
    @(posedge hclk);
    set_en <= 1'b1;
    set_idx <= 5'h1A;
    set_val <= d;
    @(posedge hclk);
    set_en <= 1'b0;
  endtask : setv

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  always @(posedge hclk) begin
    if (rd_dp === 1'b1) begin
      chk(exp_q[0].n, hrdata, exp_q[0].v);
      chk("hresp", {31'h0, hresp}, 32'h0);
      void'(exp_q.pop_front());
    end
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc > 40000) begin
      fails++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a <= 'h28; a += 4) begin
      if (a != 'h24) rd(a[7:0], a == 'h0C ? 32'h64 : a == 'h10 ? 32'h3 : 32'h0);
    end
    rd(8'h40, 32'h0);
    wr(8'h18, 32'hFFFFFFFF);
    rd(8'h18, 32'h0);
    $display("test reset done");
    wr(8'h08, 32'h7FFFFFFF);
    wr(8'h00, 32'h5);
    for (int q = 0; q < 27; q++) begin
      v = $random(seed);
      @(posedge hclk);
      set_en <= 1'b1;
      set_idx <= q[4:0];
      set_val <= v;
      @(posedge hclk);
      set_en <= 1'b0;
      wr(8'h04, q);
      repeat (90) @(posedge hclk);
      rd(8'h24, v);
    end
    $display("test selector done");
    wr(8'h08, 32'h3E8);
    wr(8'h10, 32'hA);
    wr(8'h20, 32'h3);
    setv(32'h4B0);
    for (int i = 0; i < 4; i++) begin
      p = pt[i];
      e = 4 * p * ((dl[i] + p - 1) / p);
      wr(8'h00, 32'h0);
      wr(8'h0C, dl[i]);
      wr(8'h00, (i << 2) | 1);
      while (stage_start !== 1'b1) @(posedge hclk);
      n = 0;
      while (stage_trip !== 1'b1) begin
        @(posedge hclk);
        n++;
      end
      chk("trip time", n, e);
      rd(8'h18, 32'h0064_0003);
    end
    setv(32'h3B6);
    repeat (800) @(posedge hclk);
    chk("band hold", {31'h0, stage_trip}, 32'h1);
    setv(32'h352);
    repeat (800) @(posedge hclk);
    chk("drop", {31'h0, stage_start}, 32'h0);
    rd(8'h18, 32'h0);
    chk("irq set", {31'h0, irq}, 32'h1);
    rd(8'h1C, 32'h3);
    wr(8'h1C, 32'h3);
    rd(8'h1C, 32'h0);
    chk("irq clear", {31'h0, irq}, 32'h0);
    $display("test trip done");
    wr(8'h14, 32'h1F4);
    wr(8'h0C, 32'h1E);
    wr(8'h00, 32'h3);
    setv(32'h190);
    repeat (100) @(posedge hclk);
    chk("floor", {31'h0, stage_start}, 32'h0);
    setv(32'h320);
    repeat (100) @(posedge hclk);
    chk("under", {31'h0, stage_start}, 32'h1);
    wr(8'h00, 32'h0);
    wr(8'h20, 32'h0);
    wr(8'h1C, 32'h7);
    $display("test under done");
    for (int k = 0; k < 9; k++) begin
      @(posedge hclk);
      bf_record <= 1'b1;
      rtc_date <= k + 1;
      rtc_time_ms <= k + 'h100;
      bf_elapsed_ms <= 16'(10 * k);
      bf_delay_ms <= (k == 8) ? 16'h0 : 16'h28;
      @(posedge hclk);
      bf_record <= 1'b0;
    end
    wr(8'h28, 32'h0);
    rd(8'h2C, 32'h9);
    rd(8'h30, 32'h108);
    rd(8'h34, 32'h0008_0064);
    wr(8'h28, 32'h7);
    rd(8'h2C, 32'h2);
    rd(8'h34, 32'h0008_0019);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rd(8'h1C, 32'h4);
    wr(8'h20, 32'h4);
    repeat (2) @(posedge hclk);
    chk("irq log", {31'h0, irq}, 32'h1);
    $display("test records done");
    report_and_stop();
  end
endmodule : programmable_protection_stage_tb
